//--- verilog/cpw_watchdog.sv
// Clock period watchdog of a power management device.
// Assumes all inputs synchronous to clk except monitor_clock_in,
// which is synchronised here; rails_good comes from the rail monitors.
//
// Rules of the document
// (RL1) While active it times each rising-edge interval of the monitor clock and faults when it reaches the timeout.
// (RL2) The host drives the monitor clock and keeps each period below the timeout while supervision runs.
// (RL3) Each fault pulls the reset output low for a fixed pulse of about 2 ms, then releases it; here a fault in the cycle a rail drops gives no pulse.
// (RL4) The timeout is the longest expected period, set by a resistor of 3.240 kilohm per ms, here a parameter.
// (RL5) Supervision runs only while the active-low enable is low; with it high no fault is raised.
// (RL6) Supervision starts only after all four rails have been good without a break for about 140 ms.
// (RL7) The host starts the monitor clock only after its own start-up, inside the activation delay.
// (RL8) A clock stuck for the delay plus the timeout pulses the reset, clears the counters, restarts the delay.
// (RL9) With no clock at all this repeats, so the reset output pulses low periodically.
// (RL10) A watchdog fault latches the fault code with bit0 released and bit1 pulled low.
// (RL11) All times come from counters on a free-running time base, and the clock input is synchronised first.
`timescale 1ns/1ps

module cpw_watchdog
    import cpw_pkg::*;
#(
    parameter int unsigned ACT_TICKS = ACT_DELAY_TICKS,
    parameter int unsigned PULSE_TICKS = FAULT_PULSE_TICKS,
    parameter int unsigned TIMEOUT_TICKS = PERIOD_TIMEOUT_TICKS,
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic monitor_clock_in, // Host clock under watch
    input wire logic supervisor_enable_n, // Watchdog enable, low
    input wire logic [RAIL_N-1:0] rails_good, // Rails above undervoltage
    output logic reset_output_n, // Reset pulse output, low
    output cpw_code_pins_t fault_code, // Open-drain fault code pins
    output logic supervisor_active // Interval timing running
);

    // ************************************************
    // State
    // ************************************************
    cpw_state_t state;
    cpw_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] next_pre;
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic code_wd;
    logic next_code_wd;
    logic tick;
    logic rise;
    logic all_good;
    logic fault;

    // Edge and condition decode
    assign tick = (pre == PRE_W'(TICK_LEN - 1)); // RL11
    assign rise = sync_b & ~sync_c; // RL11
    assign all_good = &rails_good;
    assign fault = ce && state == CPW_ACTIVE && !supervisor_enable_n && tick && !rise
        && cnt == CNT_W'(TIMEOUT_TICKS - 1); // RL1 RL4 RL5

    // Free-running time base prescaler
    always_comb
    begin
        next_pre = pre;
        if (ce)
        begin
            next_pre = tick ? '0 : pre + PRE_W'(1); // RL11
        end
    end

    // Next state and interval counter
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        if (ce)
        begin
            unique case (state)
                CPW_IDLE:
                begin
                    next_cnt = '0;
                    if (all_good)
                    begin
                        next_state = CPW_DELAY;
                    end
                end
                CPW_DELAY:
                begin
                    if (!all_good)
                    begin
                        next_state = CPW_IDLE; // RL6
                        next_cnt = '0;
                    end
                    else if (tick)
                    begin
                        if (cnt == CNT_W'(ACT_TICKS - 1))
                        begin
                            next_state = CPW_ACTIVE; // RL6
                            next_cnt = '0;
                        end
                        else
                        begin
                            next_cnt = cnt + CNT_W'(1);
                        end
                    end
                end
                CPW_ACTIVE:
                begin
                    if (!all_good)
                    begin
                        next_state = CPW_IDLE;
                        next_cnt = '0;
                    end
                    else if (fault)
                    begin
                        next_state = CPW_PULSE; // RL3 RL8
                        next_cnt = '0;
                    end
                    else if (supervisor_enable_n || rise)
                    begin
                        next_cnt = '0; // RL1 RL5
                    end
                    else if (tick)
                    begin
                        next_cnt = cnt + CNT_W'(1); // RL1
                    end
                end
                CPW_PULSE:
                begin
                    if (tick)
                    begin
                        if (cnt == CNT_W'(PULSE_TICKS - 1))
                        begin
                            next_state = all_good ? CPW_DELAY : CPW_IDLE; // RL8 RL9
                            next_cnt = '0;
                        end
                        else
                        begin
                            next_cnt = cnt + CNT_W'(1); // RL3
                        end
                    end
                end
            endcase
        end
    end

    // Sticky watchdog fault code
    always_comb
    begin
        next_code_wd = code_wd;
        if (ce && fault)
        begin
            next_code_wd = 1'b1; // RL10
        end
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= CPW_IDLE;
            cnt <= '0;
            pre <= '0;
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            code_wd <= CODE_RESET;
        end
        else if (ce)
        begin
            state <= next_state;
            cnt <= next_cnt;
            pre <= next_pre;
            sync_a <= monitor_clock_in; // RL11
            sync_b <= sync_a;
            sync_c <= sync_b;
            code_wd <= next_code_wd;
        end
    end

    // Outputs
    assign reset_output_n = (state != CPW_PULSE); // RL3
    assign supervisor_active = (state == CPW_ACTIVE) && !supervisor_enable_n;
    assign fault_code.bit0_o = PIN_LOW;
    assign fault_code.bit0_oe = 1'b0; // RL10
    assign fault_code.bit1_o = PIN_LOW;
    assign fault_code.bit1_oe = code_wd; // RL10

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    fault_timeout_a: assert property (fault |-> cnt == CNT_W'(TIMEOUT_TICKS - 1) && tick) // RL1
        else $error("fault without a full timeout");
    edge_clears_a: assert property (state == CPW_ACTIVE && ce && rise && all_good |=> cnt == '0) // RL1
        else $error("edge did not restart interval");
    pulse_starts_a: assert property (fault |=> !reset_output_n) // RL3
        else $error("fault did not pull reset low");
    pulse_len_a: assert property ($rose(reset_output_n) |-> $past(cnt) == CNT_W'(PULSE_TICKS - 1)) // RL3
        else $error("reset pulse length wrong");
    no_fault_off_a: assert property (supervisor_enable_n && reset_output_n |=> reset_output_n) // RL5
        else $error("reset pulse started while disabled");
    enable_hold_a: assert property (state == CPW_ACTIVE && ce && all_good && supervisor_enable_n |=> cnt == '0) // RL5
        else $error("interval counted while disabled");
    start_delay_a: assert property ($rose(state == CPW_ACTIVE) |->
        $past(cnt) == CNT_W'(ACT_TICKS - 1) && $past(all_good)) // RL6
        else $error("supervision began early");
    restart_delay_a: assert property ($rose(reset_output_n) |-> cnt == '0 &&
        (state == CPW_DELAY || state == CPW_IDLE)) // RL8 RL9
        else $error("delay not restarted after pulse");
    code_latch_a: assert property ($fell(reset_output_n) |-> fault_code.bit1_oe && !fault_code.bit0_oe) // RL10
        else $error("fault code not latched");
    tick_period_a: assert property (tick && ce |=> pre == '0) // RL11
        else $error("time base did not wrap");

    active_seen_c: cover property ($rose(state == CPW_ACTIVE));
    fault_seen_c: cover property (fault);
    pulse_end_c: cover property ($rose(reset_output_n));
    edge_ok_c: cover property (state == CPW_ACTIVE && rise);

endmodule : cpw_watchdog

//--- pkg/cpw_pkg.sv
// Constants, types and states of the clock period watchdog.
// Assumes a 20 MHz system clock and a 1 us internal time base.
package cpw_pkg;

    // ************************************************
    // Clock and time base
    // ************************************************
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_NS = 1000;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_NS / 1000;
    localparam int unsigned TICKS_PER_MS = 1_000_000 / TICK_NS;

    // ************************************************
    // Documented times
    // ************************************************
    localparam int unsigned ACT_DELAY_MS = 140;
    localparam int unsigned FAULT_PULSE_MS = 2;
    localparam int unsigned PERIOD_TIMEOUT_MS = 10;
    // Programming resistor in kilohms per millisecond of timeout
    localparam real RESISTOR_KOHM_PER_MS = 3.240;

    // Derived counts in time base ticks
    localparam int unsigned ACT_DELAY_TICKS = ACT_DELAY_MS * TICKS_PER_MS;
    localparam int unsigned FAULT_PULSE_TICKS = FAULT_PULSE_MS * TICKS_PER_MS;
    localparam int unsigned PERIOD_TIMEOUT_TICKS = PERIOD_TIMEOUT_MS * TICKS_PER_MS;

    // ************************************************
    // Widths, resets and types
    // ************************************************
    localparam int unsigned CNT_W = 24;
    localparam int unsigned PRE_W = 8;
    localparam int unsigned RAIL_N = 4;
    localparam logic CODE_RESET = 1'b0;
    localparam logic PIN_LOW = 1'b0;

    typedef enum logic [1:0] {
        CPW_IDLE,
        CPW_DELAY,
        CPW_ACTIVE,
        CPW_PULSE
    } cpw_state_t;

    // Open-drain fault code pins
    typedef struct packed {
        logic bit1_o;
        logic bit1_oe;
        logic bit0_o;
        logic bit0_oe;
    } cpw_code_pins_t;

endpackage : cpw_pkg

//--- testbench/cpw_host_model.sv
// Host side model: drives the watched clock of the watchdog.
// Assumes half_cycles >= 1; run low leaves the line stuck at its level.
`timescale 1ns/1ps

module cpw_host_model
(
    input wire logic clk, // System clock
    input wire logic run, // High while the host delivers its clock
    input wire logic [7:0] half_cycles, // Half period in clk cycles
    output logic monitor_clock_in // Watched clock toward the device
);
    logic [7:0] phase_cnt;

    // Toggle every half period, only after the host chose to start
    initial
    begin
        monitor_clock_in = 1'b0;
        phase_cnt = 8'h00;
    end
    always @(negedge clk)
    begin
        if (run)
        begin
            if (phase_cnt + 8'h01 >= half_cycles)
            begin
                phase_cnt <= 8'h00;
                monitor_clock_in <= ~monitor_clock_in;
            end
            else
                phase_cnt <= phase_cnt + 8'h01;
        end
    end
endmodule : cpw_host_model

//--- testbench/cpw_watchdog_bench.sv
// Self-checking bench of the clock period watchdog.
// Assumes shortened counts: tick of 2 cycles, delay 20, timeout 10, pulse 4 ticks.
`timescale 1ns/1ps

module cpw_watchdog_bench;
    import cpw_pkg::*;
    localparam int unsigned PULSE_CYC = 8;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1, run = 1'b0, enable_n = 1'b0, mon_clk, rst_out_n, active;
    logic [RAIL_N-1:0] rails = '0;
    logic [7:0] half = 8'h06;
    cpw_code_pins_t fault_code;
    int n_errors = 0, check_count = 0, cyc = 0, pulses = 0, last_fall = 0, prev_fall = 0, t0, seed = 92, idx;
    int notes[$];

    cpw_host_model host (.clk(clk), .run(run), .half_cycles(half), .monitor_clock_in(mon_clk));
    cpw_watchdog #(.ACT_TICKS(20), .PULSE_TICKS(4), .TIMEOUT_TICKS(10), .TICK_LEN(2)) dut (
        .clk(clk), .rst(rst), .ce(ce), .monitor_clock_in(mon_clk), .supervisor_enable_n(enable_n),
        .rails_good(rails), .reset_output_n(rst_out_n), .fault_code(fault_code), .supervisor_active(active));

    // ************************************************
    // Clock, timeout and shared tasks
    // ************************************************
    initial
    begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_pulses(input int n);
        for (int i = 0; i < 3000 && !(pulses >= n && rst_out_n === 1'b1); i++)
            @(negedge clk);
        chk("pulse count", n, pulses);
    endtask : wait_pulses
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // ************************************************
    // Monitor: each reset pulse takes the oldest note
    // ************************************************
    initial
    begin
        int len;
        forever
        begin
            @(negedge rst_out_n);
            // Look mid-cycle, away from the edge that launched the fall
            @(negedge clk);
            prev_fall = last_fall;
            last_fall = cyc;
            chk("code bit1 pulls low", 1'b1, fault_code.bit1_oe);
            chk("code bit1 level", 1'b0, fault_code.bit1_o);
            chk("code bit0 released", 1'b0, fault_code.bit0_oe);
            len = 0;
            while (rst_out_n !== 1'b1 && len < 100)
            begin
                len++;
                @(negedge clk);
            end
            if (notes.size() == 0)
                chk("unexpected pulse", 1'b0, 1'b1);
            else
                chk("pulse length", notes.pop_front(), len);
            pulses++;
        end
    end

    // ************************************************
    // Stimulus
    // ************************************************
    initial
    begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        // Good host clock of random period below the timeout
        rails = '1;
        half = 8'h04 + 8'($unsigned($random(seed)) % 6);
        run = 1'b1;
        repeat (150) @(negedge clk);
        chk("supervision running", 1'b1, active);
        repeat (200) @(negedge clk);
        chk("no fault code yet", 1'b0, fault_code.bit1_oe);
        // Stuck clock: periodic pulses with counters restarted
        repeat (3) notes.push_back(PULSE_CYC);
        run = 1'b0;
        wait_pulses(3);
        chk("repeat interval", 1'b1, (last_fall - prev_fall) inside {[66:71]});
        run = 1'b1;
        repeat (200) @(negedge clk);
        // Period just over the timeout faults, just under does not
        half = 8'h09;
        repeat (200) @(negedge clk);
        notes.push_back(PULSE_CYC);
        half = 8'h0B;
        wait_pulses(4);
        half = 8'h06;
        repeat (200) @(negedge clk);
        // Enable high blocks faults, counter restarts on enable
        enable_n = 1'b1;
        run = 1'b0;
        repeat (200) @(negedge clk);
        chk("idle while disabled", 1'b0, active);
        notes.push_back(PULSE_CYC);
        enable_n = 1'b0;
        t0 = cyc;
        wait_pulses(5);
        chk("fault after enable", 1'b1, (last_fall - t0) inside {[18:24]});
        // Rail loss holds off supervision until rails good for the delay
        idx = $unsigned($random(seed)) % RAIL_N;
        rails[idx] = 1'b0;
        repeat (200) @(negedge clk);
        notes.push_back(PULSE_CYC);
        rails = '1;
        t0 = cyc;
        wait_pulses(6);
        chk("fault after delay", 1'b1, (last_fall - t0) inside {[58:66]});
        run = 1'b1;
        repeat (150) @(negedge clk);
        // Clock enable low freezes everything: no fault however long the stall
        ce = 1'b0;
        run = 1'b0;
        repeat (200) @(negedge clk);
        chk("frozen reset output", 1'b1, rst_out_n);
        chk("frozen supervision", 1'b1, active);
        notes.push_back(PULSE_CYC);
        ce = 1'b1;
        wait_pulses(7);
        // Mid-run reset clears the sticky fault code
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk("code cleared by reset", 1'b0, fault_code.bit1_oe);
        chk("reset output after reset", 1'b1, rst_out_n);
        chk("notes left", 0, notes.size());
        tally_and_finish();
    end
endmodule : cpw_watchdog_bench
